//--- logic/fes_supervisor.sv
// Error supervisor of the position_unit fieldbus master
// Behaviour
// - Check commands and inputs at issue and motion
// - Estop or limit error reported in preference
// - Continue mode: stop only failing slave
// - Continue: set error bit, axis code 00A9
// - Continue: flag slaves still in cyclic exchange
// - Stop mode: halt cyclic exchange to all
// - Stop mode: reachable slaves held pre-operational
// - Stop: set error bit, report unit cause
// - Stop: flag slaves able to exchange messages
// - Stop: no restart while any cause remains
// - Link faults give unit codes 00A0/A3/A4
// - Cyclic failure gives 00A6 and error bit
// - Drive inputs give 5007, 5008, 5009
// - Drive estop gives 500D only
// - Other drive faults give 500F only
// - Stop mode link error raises unit error
// - Continue mode link error: axis only
// - Error reset clears unit error, restarts
// - Pending errors presented one at a time
`timescale 1ns/1ps
`include "fes_defs.svh"

module fes_supervisor (
  input  wire logic                        ref_clk_i,
  input  wire logic                        srst_i,
  input  wire logic                        stop_mode_i,      // 1 = stop all on link error
  input  wire logic                        err_reset_i,      // Host error reset command bit
  input  wire logic                        cmd_active_i,     // Command issued or motion running
  input  wire logic                        cmd_bad_i,        // Command data or soft limit fault
  input  wire fes_pkg::fes_link_evt_t      link_evt_i,       // Link fault event from engine
  input  wire logic [`FES_NODES-1:0]       reachable_i,      // Slaves still reachable
  input  wire logic [`FES_NODES-1:0]       cause_i,          // Slave fault cause still present
  input  wire fes_pkg::fes_drv_in_t [`FES_NODES-1:0] drv_i,  // Drive inputs (from pins)
  output logic [15:0]                      unit_code_o,      // Unit error code, 0 = none
  output logic                             unit_err_o,       // Unit error flag
  output logic [`FES_NODES-1:0][15:0]      axis_code_o,      // Axis error code per node
  output logic [`FES_NODES-1:0]            err_tbl_o,        // Error slave table
  output logic [`FES_NODES-1:0]            norm_tbl_o,       // Normal slave table
  output logic [`FES_NODES-1:0]            msg_tbl_o,        // Message-enabled table
  output logic [`FES_NODES-1:0]            cyc_en_o          // Cyclic exchange enable
);
  // Node count fixed at build; every table is one bit per node
  localparam int N = `FES_NODES;

  // Three-stage samplers for drive pins; the first stage feeds only the second
  fes_pkg::fes_drv_in_t [N-1:0] s1_q;
  fes_pkg::fes_drv_in_t [N-1:0] s2_q;
  fes_pkg::fes_drv_in_t [N-1:0] s3_q;
  fes_pkg::fes_drv_in_t [N-1:0] drv_q;   // Filtered, accepted level
  // Error reset edge detection
  logic                         rst_q;   // Previous reset bit
  logic                         rst_pulse;
  // Supervision state
  logic [15:0]                  cmd_code_q; // Pending command error
  logic [N-1:0]                 stopped_q;  // Slaves whose cyclic exchange halted
  logic                         stop_all_q; // Global halt in stop mode
  // Next values of the status registers
  logic [N-1:0][15:0]           axis_q;
  logic [15:0]                  unit_q;

  // Synchroniser chain
  // No reset: the chain flushes itself within three edges
  always_ff @(posedge ref_clk_i)
  begin
    s1_q <= drv_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // Change accepted once stages two and three agree
  // A level that flickers between stages is held back
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      drv_q <= '0;
    else if (s2_q == s3_q)
      drv_q <= s3_q;
  end

  // Reset edge detect; holding the bit does not repeat the reset
  // Cleared on reset, so a bit held through reset acts once after it
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      rst_q <= 1'b0;
    else
      rst_q <= err_reset_i;
  end
  assign rst_pulse = err_reset_i & ~rst_q;

  // Command and limit checks, both at issue and throughout motion
  // Set outranks clear, so a fault during an error reset is kept
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      cmd_code_q <= `FES_CODE_NONE;
    else if (cmd_active_i && cmd_bad_i)
      cmd_code_q <= `FES_CODE_CMD;
    else if (rst_pulse)
      cmd_code_q <= `FES_CODE_NONE;
  end

  // Per-slave link fault handling and tables
  // A reset reloads from the live causes, so only healed slaves restart
  // Halted slaves stay halted until such a reset
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      stopped_q  <= '0;
      stop_all_q <= 1'b0;
      err_tbl_o  <= '0;
    end
    else
    begin
      // Reset first, so a fault in the same cycle still lands (set wins)
      if (rst_pulse)
      begin
        err_tbl_o <= cause_i;
        stopped_q <= cause_i;
        // Global halt stays while any cause remains
        if (cause_i == '0)
          stop_all_q <= 1'b0;
      end
      if (link_evt_i.valid)
      begin
        err_tbl_o[link_evt_i.node] <= 1'b1;
        stopped_q[link_evt_i.node] <= 1'b1;
        if (stop_mode_i)
          stop_all_q <= 1'b1;
      end
    end
  end

  // Exchange enables and status tables
  // Halted slaves drop out of both cyclic tables in the same edge
  // The message table ignores the halt: pre-operational slaves still talk
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      cyc_en_o   <= '0;
      norm_tbl_o <= '0;
      msg_tbl_o  <= '0;
    end
    else
    begin
      // Cyclic only for reachable, not halted slaves
      cyc_en_o   <= stop_all_q ? '0 : (reachable_i & ~stopped_q);
      norm_tbl_o <= stop_all_q ? '0 : (reachable_i & ~stopped_q);
      // Pre-operational slaves still take messages
      msg_tbl_o  <= reachable_i;
    end
  end

  // Axis codes: estop and limits outrank other causes
  // One priority chain per node; the first true cause wins
  // A link flag hides a plain drive fault until an error reset finds its cause healed
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (drv_q[i].estop)
        axis_q[i] = `FES_CODE_ESTOP;
      else if (drv_q[i].fwd_lim)
        axis_q[i] = `FES_CODE_FWDLIM;
      else if (drv_q[i].rev_lim)
        axis_q[i] = `FES_CODE_REVLIM;
      else if (drv_q[i].main_off)
        axis_q[i] = `FES_CODE_MAINOFF;
      else if (err_tbl_o[i])
        axis_q[i] = `FES_CODE_AXCOMM;
      else if (drv_q[i].drv_fault)
        axis_q[i] = `FES_CODE_DRVERR;
      else
        axis_q[i] = `FES_CODE_NONE;
    end
  end

  // Axis status registers
  // One edge behind the filtered pins
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      axis_code_o <= '0;
    else
      axis_code_o <= axis_q;
  end

  // Unit code from link event; only in stop mode
  // Order matters: reset, then command fault, then link event
  // Continue mode leaves the unit code untouched
  always_comb
  begin
    unit_q = unit_code_o;
    if (rst_pulse)
      unit_q = cmd_code_q == `FES_CODE_NONE ? `FES_CODE_NONE : cmd_code_q;
    if (cmd_active_i && cmd_bad_i && unit_q == `FES_CODE_NONE)
      unit_q = `FES_CODE_CMD;
    // Kinds outside the four faults keep the code as it is
    if (link_evt_i.valid && stop_mode_i)
    begin
      unique case (link_evt_i.kind)
        fes_pkg::FES_LF_INIT: unit_q = `FES_CODE_INIT;
        fes_pkg::FES_LF_CFG:  unit_q = `FES_CODE_CFG;
        fes_pkg::FES_LF_AL:   unit_q = `FES_CODE_AL;
        fes_pkg::FES_LF_PDO:  unit_q = `FES_CODE_PDO;
        default:              unit_q = unit_q;
      endcase
    end
  end

  // Unit status
  // Flag comes from the same next value, so both move together
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      unit_code_o <= `FES_CODE_NONE;
      unit_err_o  <= 1'b0;
    end
    else
    begin
      unit_code_o <= unit_q;
      unit_err_o  <= unit_q != `FES_CODE_NONE;
    end
  end

  // Checks
  // A global halt empties the cyclic enables on the next edge
  AST_STOP_ALL: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    stop_all_q |=> cyc_en_o == '0) else $error("cyclic exchange during global halt");

  // Continue mode: the failing slave leaves cyclic exchange two edges later
  AST_CONT_ONE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    link_evt_i.valid && !stop_mode_i && !stop_all_q |=> ##1 !cyc_en_o[$past(link_evt_i.node, 2)])
    else $error("failed slave still cyclic");

  // Every link event flags its node in the error table
  AST_ERR_BIT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    link_evt_i.valid |=> err_tbl_o[$past(link_evt_i.node)]) else $error("error bit not set");

  // Continue mode leaves the unit code alone
  AST_NO_UNIT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    link_evt_i.valid && !stop_mode_i && !rst_pulse && !cmd_bad_i |=> $stable(unit_code_o))
    else $error("unit error in continue mode");

  // Stop mode: a cyclic failure shows as its unit code
  AST_PDO: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    link_evt_i.valid && stop_mode_i && link_evt_i.kind == fes_pkg::FES_LF_PDO
    |=> unit_code_o == `FES_CODE_PDO) else $error("missing 00A6");

  // Stop mode: an application-layer state error shows as its unit code
  AST_AL_CODE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    link_evt_i.valid && stop_mode_i && link_evt_i.kind == fes_pkg::FES_LF_AL
    |=> unit_code_o == `FES_CODE_AL) else $error("missing application-layer code");

  // Emergency stop outranks every other axis cause
  AST_ESTOP: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    drv_q[0].estop |=> axis_code_o[0] == `FES_CODE_ESTOP) else $error("estop not preferred");

  // Forward limit outranks everything but the emergency stop
  AST_FWD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    drv_q[0].fwd_lim && !drv_q[0].estop |=> axis_code_o[0] == `FES_CODE_FWDLIM)
    else $error("forward limit code missing");

  // A command fault is latched while the command is live
  AST_CMD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_active_i && cmd_bad_i |=> cmd_code_q == `FES_CODE_CMD)
    else $error("command fault not latched");

  // Global halt survives an error reset while a cause remains
  AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    stop_all_q && cause_i != '0 |=> stop_all_q) else $error("restart with cause present");

  // Error reset with every cause gone lifts the halt and empties the table
  AST_RESTART: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rst_pulse && cause_i == '0 && !link_evt_i.valid |=> !stop_all_q && err_tbl_o == '0)
    else $error("error reset did not restart");

  // After a clear the next pending error comes up
  AST_NEXT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rst_pulse && !link_evt_i.valid && !(cmd_active_i && cmd_bad_i)
    |=> unit_code_o == $past(cmd_code_q)) else $error("pending error not shown");

  // A held reset bit acts only once
  AST_EDGE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    err_reset_i ##1 err_reset_i |-> !rst_pulse) else $error("held reset repeated");

  // Message table follows the reachable slaves, from the first edge out of reset
  AST_MSG: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !srst_i |=> msg_tbl_o == $past(reachable_i)) else $error("message table wrong");

  // Cyclic exchange only with slaves that also take messages
  AST_NORM: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (norm_tbl_o & ~msg_tbl_o) == '0) else $error("normal flag on unreachable slave");

  // Main scenarios
  COV_STOP: cover property (@(posedge ref_clk_i) link_evt_i.valid && stop_mode_i);
  COV_CONT: cover property (@(posedge ref_clk_i) link_evt_i.valid && !stop_mode_i);
  COV_RST: cover property (@(posedge ref_clk_i) rst_pulse && stop_all_q);
  COV_NEXT: cover property (@(posedge ref_clk_i) rst_pulse && cmd_code_q != `FES_CODE_NONE);
  COV_ESTOP: cover property (@(posedge ref_clk_i) drv_q[0].estop);
endmodule

//--- logic/fes_defs.svh
// Constants for the fieldbus error supervisor
`ifndef FES_DEFS_SVH
`define FES_DEFS_SVH
`define FES_NODES        8
`define FES_CODE_NONE    16'h0000
`define FES_CODE_INIT    16'h00A0
`define FES_CODE_CFG     16'h00A3
`define FES_CODE_AL      16'h00A4
`define FES_CODE_PDO     16'h00A6
`define FES_CODE_AXCOMM  16'h00A9
`define FES_CODE_MAINOFF 16'h5007
`define FES_CODE_FWDLIM  16'h5008
`define FES_CODE_REVLIM  16'h5009
`define FES_CODE_ESTOP   16'h500D
`define FES_CODE_DRVERR  16'h500F
`define FES_CODE_CMD     16'h0010
`endif

//--- logic/fes_pkg.sv
// Types shared by the fieldbus error supervisor
package fes_pkg;
  // Link fault kinds reported by the network engine
  typedef enum logic [2:0] {
    FES_LF_NONE,
    FES_LF_INIT,
    FES_LF_CFG,
    FES_LF_AL,
    FES_LF_PDO
  } fes_link_kind_t;

  // One link fault event
  typedef struct packed {
    logic           valid;
    logic [2:0]     node;
    fes_link_kind_t kind;
  } fes_link_evt_t;

  // Drive-side inputs per axis
  typedef struct packed {
    logic main_off;
    logic fwd_lim;
    logic rev_lim;
    logic estop;
    logic drv_fault;
  } fes_drv_in_t;

  // Exchange state of a slave
  typedef enum logic [1:0] {
    FES_ST_OP,
    FES_ST_PREOP,
    FES_ST_DOWN
  } fes_slave_st_t;
endpackage

//--- testbench/fes_slave_model.sv
// Behavioural model of the servo drive slaves on the fieldbus
`timescale 1ns/1ps
module fes_slave_model (
  input  wire logic                       ref_clk_i,
  input  wire logic [7:0]                 cyc_en_i,     // Cyclic enables, seen only
  output fes_pkg::fes_link_evt_t          link_evt_o,   // Fault report to the master
  output logic [7:0]                      reachable_o,  // Slaves answering on the chain
  output logic [7:0]                      cause_o,      // Unremoved fault causes
  output fes_pkg::fes_drv_in_t [7:0]      drv_o         // Drive-side input pins
);
  // Whole chain up and healthy at power on
  initial
  begin
    link_evt_o  = '0;
    reachable_o = 8'hff;
    cause_o     = 8'h00;
    drv_o       = '0;
  end

  // Slave fault: cause stays until healed, report is a one-cycle pulse
  task automatic fault(input logic [2:0] n, input fes_pkg::fes_link_kind_t k);
    @(posedge ref_clk_i);
    cause_o[n] <= 1'b1;
    link_evt_o <= '{1'b1, n, k};
    @(posedge ref_clk_i);
    link_evt_o.valid <= 1'b0;
  endtask

  // Operator removes the cause at the slave
  task automatic heal(input logic [2:0] n);
    @(posedge ref_clk_i);
    cause_o[n] <= 1'b0;
  endtask

  // A slave falls off the chain or comes back
  task automatic reach(input logic [2:0] n, input logic v);
    @(posedge ref_clk_i);
    reachable_o[n] <= v;
  endtask

  // Drive input pins of one axis
  task automatic pins(input logic [2:0] n, input fes_pkg::fes_drv_in_t v);
    @(posedge ref_clk_i);
    drv_o[n] <= v;
  endtask
endmodule

//--- testbench/fieldbus_error_supervisor_tb.sv
// Self-checking bench for the fieldbus error supervisor
`timescale 1ns/1ps
module fieldbus_error_supervisor_tb;
  logic                       ref_clk_i, srst_i, stop_mode_i, err_reset_i;
  logic                       cmd_active_i, cmd_bad_i, unit_err;
  fes_pkg::fes_link_evt_t     evt;
  fes_pkg::fes_drv_in_t [7:0] drv;
  logic [7:0]                 reach, cause, cyc_en, err_tbl, norm_tbl, msg_tbl;
  logic [7:0][15:0]           axis_code;
  logic [15:0]                unit_code;
  int                         fail_count, checked;
  // Expected codes per link kind and per pin pattern
  logic [15:0] lcode [1:3] = '{16'h00a0, 16'h00a3, 16'h00a4};
  logic [4:0]  pat [6]     = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03};
  logic [15:0] pcode [6]   = '{16'h5007, 16'h5008, 16'h5009, 16'h500d, 16'h500f, 16'h500d};

  fes_supervisor dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .stop_mode_i(stop_mode_i),
    .err_reset_i(err_reset_i), .cmd_active_i(cmd_active_i), .cmd_bad_i(cmd_bad_i),
    .link_evt_i(evt), .reachable_i(reach), .cause_i(cause), .drv_i(drv),
    .unit_code_o(unit_code), .unit_err_o(unit_err), .axis_code_o(axis_code),
    .err_tbl_o(err_tbl), .norm_tbl_o(norm_tbl), .msg_tbl_o(msg_tbl), .cyc_en_o(cyc_en));
  fes_slave_model sl_u (.ref_clk_i(ref_clk_i), .cyc_en_i(cyc_en), .link_evt_o(evt),
    .reachable_o(reach), .cause_o(cause), .drv_o(drv));

  // Free-running clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Compare and count
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Let registered outputs land, away from the edge
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Host pulses the error reset bit, edge is what counts
  task automatic errrst;
    @(posedge ref_clk_i);
    err_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    err_reset_i <= 1'b0;
    settle(3);
  endtask

  // Verdict, also reached by the watchdog
  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial
  begin
    #40000;
    fail_count++;
    results;
  end

  // Test sequence
  initial
  begin
    srst_i = 1'b1;
    stop_mode_i = 1'b1;
    err_reset_i = 1'b0;
    cmd_active_i = 1'b0;
    cmd_bad_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    // Stop mode, cyclic failure on node 3
    sl_u.fault(3, fes_pkg::FES_LF_PDO);
    sl_u.reach(5, 1'b0);
    settle(3);
    check("unit_code", unit_code, 16'h00a6);
    check("unit_err", unit_err, 16'h0001);
    check("err_tbl", err_tbl, 16'h0008);
    check("cyc_en", cyc_en, 16'h0000);
    check("msg_tbl", msg_tbl, 16'h00df);
    sl_u.reach(5, 1'b1);
    // Reset while the cause is still there keeps the halt
    errrst;
    check("cyc_en", cyc_en, 16'h0000);
    check("err_tbl", err_tbl, 16'h0008);
    sl_u.heal(3);
    errrst;
    check("unit_code", unit_code, 16'h0000);
    check("cyc_en", cyc_en, 16'h00ff);
    // Remaining link fault kinds
    for (int k = 1; k <= 3; k++)
    begin
      sl_u.fault(k[2:0], fes_pkg::fes_link_kind_t'(k));
      settle(3);
      check("unit_code", unit_code, lcode[k]);
      sl_u.heal(k[2:0]);
      errrst;
    end
    // Continue mode, node 2 only drops out
    @(posedge ref_clk_i);
    stop_mode_i <= 1'b0;
    sl_u.fault(2, fes_pkg::FES_LF_AL);
    settle(3);
    check("unit_code", unit_code, 16'h0000);
    check("err_tbl", err_tbl, 16'h0004);
    check("axis2", axis_code[2], 16'h00a9);
    check("cyc_en", cyc_en, 16'h00fb);
    check("norm_tbl", norm_tbl, 16'h00fb);
    sl_u.heal(2);
    errrst;
    // Drive pins, last pattern has estop over drive fault
    for (int i = 0; i < 6; i++)
    begin
      sl_u.pins(0, fes_pkg::fes_drv_in_t'(pat[i]));
      settle(6);
      check("axis0", axis_code[0], pcode[i]);
      check("unit_code", unit_code, 16'h0000);
      check("err_tbl", err_tbl, 16'h0000);
      sl_u.pins(0, '0);
      settle(6);
      errrst;
    end
    // Bad command while active
    @(posedge ref_clk_i);
    cmd_active_i <= 1'b1;
    cmd_bad_i <= 1'b1;
    settle(3);
    check("unit_code", unit_code, 16'h0010);
    // Stop-mode link error overrides, the command error waits its turn
    @(posedge ref_clk_i);
    cmd_bad_i <= 1'b0;
    stop_mode_i <= 1'b1;
    sl_u.fault(6, fes_pkg::FES_LF_CFG);
    settle(3);
    check("unit_code", unit_code, 16'h00a3);
    sl_u.heal(6);
    // Reset bit held on: the clear happens once, the next error stays
    @(posedge ref_clk_i);
    err_reset_i <= 1'b1;
    settle(3);
    check("unit_code", unit_code, 16'h0010);
    sl_u.fault(4, fes_pkg::FES_LF_INIT);
    settle(3);
    check("unit_code", unit_code, 16'h00a0);
    check("err_tbl", err_tbl, 16'h0010);
    sl_u.heal(4);
    @(posedge ref_clk_i);
    err_reset_i <= 1'b0;
    errrst;
    check("unit_code", unit_code, 16'h0000);
    check("unit_err", unit_err, 16'h0000);
    results;
  end
endmodule
